// ===== verilog/melody_pkg.sv
// Constants shared by the melody play controller files
package melody_pkg;

   // APB register byte offsets
   localparam logic [7:0] OFS_CTRL  = 8'h00;
   localparam logic [7:0] OFS_MODE  = 8'h04;
   localparam logic [7:0] OFS_CKS   = 8'h08;
   localparam logic [7:0] OFS_MSEL  = 8'h0c;
   localparam logic [7:0] OFS_MASK  = 8'h10;
   localparam logic [7:0] OFS_FLAG  = 8'h14;
   localparam logic [7:0] OFS_RADDR = 8'h18;
   localparam logic [7:0] OFS_RDATA = 8'h1c;

   // Field positions
   localparam int TRIG_BIT = 0;
   localparam int STAT_BIT = 1;
   localparam int RSEL_LSB = 10;
   localparam int KIND_LSB = 8;
   localparam int TSW_BIT  = 7;
   localparam int DUR_LSB  = 4;

   // Play modes
   localparam logic [1:0] MODE_LEVEL = 2'h0;
   localparam logic [1:0] MODE_SS    = 2'h1;
   localparam logic [1:0] MODE_ONE_A = 2'h2;
   localparam logic [1:0] MODE_ONE_C = 2'h3;

   // Memory selection for the load window
   localparam logic [1:0] ROM_SCORE = 2'h0;
   localparam logic [1:0] ROM_SCALE = 2'h1;
   localparam logic [1:0] ROM_CTL   = 2'h2;
   localparam logic [1:0] ROM_START = 2'h3;

   // Score entry kinds
   localparam logic [1:0] KIND_NOTE = 2'h0;
   localparam logic [1:0] KIND_REST = 2'h1;
   localparam logic [1:0] KIND_JUMP = 2'h2;
   localparam logic [1:0] KIND_END  = 2'h3;

   // Memory sizes
   localparam int SCORE_WORDS = 512;
   localparam int SCORE_W     = 10;
   localparam int SCORE_USED  = 495;
   localparam int SCALE_WORDS = 16;
   localparam int SCALE_W     = 8;
   localparam int CTL_WORDS   = 96;
   localparam int CTL_W       = 10;
   localparam int START_WORDS = 16;
   localparam int START_W     = 7;
   localparam int TEMPO_NUM   = 16;

   // Control memory layout relative to a melody's entry
   localparam logic [6:0] CTL_TEMPO_OFS = 7'h01;
   localparam logic [6:0] CTL_JUMP_OFS  = 7'h02;

   // Timing
   localparam int CLK_MHZ       = 25;
   localparam int TRIG_HOLD_US  = 27400;
   localparam int TRIG_HOLD_CYC = TRIG_HOLD_US * CLK_MHZ;
   localparam int REF_32K_HZ    = 32768;
   localparam int REF_38K_HZ    = 38400;
   // Seconds per minute times ten, over four sixteenths per beat
   localparam int SIXTEENTH_NUM = 150;

   // Fixed tempo table, beats per minute times ten
   localparam int TEMPO_BPM10 [TEMPO_NUM] = '{4800, 2400, 1600, 1200, 960, 800, 686, 600,
                                             535, 480, 436, 400, 369, 343, 320, 300};

   // Length of each of the eight duration codes, in sixteenths
   function automatic logic [4:0] dur_units(input logic [2:0] code);
      case (code)
         3'h0:    dur_units = 5'h01;
         3'h1:    dur_units = 5'h02;
         3'h2:    dur_units = 5'h03;
         3'h3:    dur_units = 5'h04;
         3'h4:    dur_units = 5'h06;
         3'h5:    dur_units = 5'h08;
         3'h6:    dur_units = 5'h0c;
         default: dur_units = 5'h10;
      endcase
   endfunction : dur_units

endpackage : melody_pkg

// ===== verilog/tone_divider.sv
// Pitch divider that toggles the buzzer line from the reference tick
module tone_divider
#(
   parameter int RATIO_W = 8,
   parameter bit IDLE_LEVEL = 1'b0
)
(
   // Clock, reset, enable
   input  wire logic               mclk_in,
   input  wire logic               rst_in,
   input  wire logic               ce_in,
   // Control
   input  wire logic               ref_tick_in,
   input  wire logic               sound_in,
   input  wire logic [RATIO_W-1:0] ratio_in,
   // Buzzer line
   output logic                    tone_out
);

   logic [RATIO_W-1:0]      cnt_ff;
   wire logic [RATIO_W-1:0] inc_w  = cnt_ff + RATIO_W'(1);
   wire logic               wrap_w = (inc_w >= ratio_in);

   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         cnt_ff   <= '0;
         tone_out <= IDLE_LEVEL;
      end
      else if (ce_in)
      begin
         if (!sound_in)
         begin
            cnt_ff   <= '0;
            tone_out <= IDLE_LEVEL;
         end
         else if (ref_tick_in)
         begin
            cnt_ff   <= wrap_w ? '0 : inc_w;
            tone_out <= wrap_w ? ~tone_out : tone_out;
         end
      end
   end

endmodule : tone_divider

// ===== verilog/melody_play_controller.sv
// Melody play controller: APB registers, score sequencer, checks
module melody_play_controller
   import melody_pkg::*;
#(
   parameter int unsigned HOLD_CYC  = TRIG_HOLD_CYC,
   parameter int unsigned REF_HZ    = REF_32K_HZ,
   parameter bit          CHANGE_OK = 1'b1,
   parameter bit          IDLE_LVL  = 1'b0
)
(
   // Clock, reset, enable
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   // APB slave
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // Oscillator and shared interrupt
   input  wire logic        low_speed_osc_in,
   input  wire logic        ga_irq_in,
   output logic             irq_out,
   // Buzzer drive
   output logic             melody_out
);

   localparam int HW = $clog2(HOLD_CYC + 1);
   localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYC - 1);
   localparam logic [15:0]   TICK_ONE  = 16'h0001;
   localparam logic [4:0]    DUR_ONE   = 5'h01;

   typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_NOTE, ST_PLAY} seq_e;

   // Software registers
   logic                trig_ff;
   logic [1:0]          mode_ff;
   logic [1:0]          cks_ff;
   logic [3:0]          msel_ff;
   logic                mask_ff;
   logic                flag_ff;
   logic                status_ff;
   logic [11:0]         raddr_ff;

   // Melody memories, loaded over the bus
   logic [SCORE_W-1:0]  score_mem [SCORE_WORDS];
   logic [SCALE_W-1:0]  scale_mem [SCALE_WORDS];
   logic [CTL_W-1:0]    ctl_mem   [CTL_WORDS];
   logic [START_W-1:0]  start_mem [START_WORDS];

   // Sequencer state
   seq_e                st_ff;
   logic [3:0]          mel_ff;
   logic [6:0]          base_ff;
   logic [8:0]          ptr_ff;
   logic [3:0]          tempo_a_ff;
   logic [3:0]          tempo_b_ff;
   logic                tsel_ff;
   logic [15:0]         tick_ff;
   logic [4:0]          dur_ff;
   logic [7:0]          ratio_ff;
   logic                sound_ff;
   logic                stop_req_ff;
   logic                chg_req_ff;
   logic                armed_ff;
   logic [HW-1:0]       hold_ff;
   logic                osc_q_ff;
   logic [1:0]          div_ff;
   logic                ref_tick_ff;

   // Guarded read of the control memory
   function automatic logic [CTL_W-1:0] ctl_at(input logic [6:0] idx);
      ctl_at = (int'(idx) < CTL_WORDS) ? ctl_mem[idx] : '0;
   endfunction : ctl_at

   // Bus decode
   wire logic        setup_w   = psel_in & ~penable_in;
   wire logic        wr_w      = psel_in & penable_in & pwrite_in & pready_out;
   wire logic        wr_ctrl_w = wr_w && (paddr_in == OFS_CTRL);
   wire logic        wr_msel_w = wr_w && (paddr_in == OFS_MSEL);
   wire logic        wr_flag_w = wr_w && (paddr_in == OFS_FLAG);
   wire logic        wr_rom_w  = wr_w && (paddr_in == OFS_RDATA);
   wire logic        hit_w     = (paddr_in[1:0] == 2'h0) && (paddr_in <= OFS_RDATA);
   wire logic        trig_wr1_w  = wr_ctrl_w & pwdata_in[TRIG_BIT];
   wire logic        trig_wr0_w  = wr_ctrl_w & ~pwdata_in[TRIG_BIT];
   wire logic        trig_rise_w = trig_wr1_w & ~trig_ff;
   wire logic [1:0]  rsel_w    = raddr_ff[RSEL_LSB+:2];
   wire logic [31:0] rom_rd_w  =
      (rsel_w == ROM_SCORE) ? 32'(score_mem[raddr_ff[8:0]]) :
      (rsel_w == ROM_SCALE) ? 32'(scale_mem[raddr_ff[3:0]]) :
      (rsel_w == ROM_CTL)   ? 32'(ctl_at(raddr_ff[6:0])) :
                              32'(start_mem[raddr_ff[3:0]]);
   wire logic [31:0] rd_w =
      (paddr_in == OFS_CTRL)  ? 32'({status_ff, trig_ff}) :
      (paddr_in == OFS_MODE)  ? 32'(mode_ff) :
      (paddr_in == OFS_CKS)   ? 32'(cks_ff) :
      (paddr_in == OFS_MSEL)  ? 32'(msel_ff) :
      (paddr_in == OFS_MASK)  ? 32'(mask_ff) :
      (paddr_in == OFS_FLAG)  ? 32'(flag_ff) :
      (paddr_in == OFS_RADDR) ? 32'(raddr_ff) :
      (paddr_in == OFS_RDATA) ? rom_rd_w : 32'h0000_0000;

   // Reference tick: oscillator edge divided down to the reference rate
   wire logic        osc_edge_w = low_speed_osc_in & ~osc_q_ff;
   wire logic        div_last_w = cks_ff[1] ? (div_ff == 2'h3) :
                                  cks_ff[0] ? div_ff[0] : 1'b1;

   // Fixed tempo table as reference ticks per sixteenth
   logic [15:0] tempo_tbl_w [TEMPO_NUM];
   for (genvar g = 0; g < TEMPO_NUM; g++)
   begin : g_tempo
      assign tempo_tbl_w[g] = 16'((REF_HZ * SIXTEENTH_NUM) / TEMPO_BPM10[g]);
   end

   // Sequencer decode
   wire logic [6:0]       start_idx_w = start_mem[mel_ff];
   wire logic [CTL_W-1:0] start_wd_w  = ctl_at(start_idx_w);
   wire logic [CTL_W-1:0] tempo_wd_w  = ctl_at(7'(start_idx_w + CTL_TEMPO_OFS));
   wire logic [SCORE_W-1:0] word_w    = score_mem[ptr_ff];
   wire logic [1:0]       kind_w      = word_w[KIND_LSB+:2];
   wire logic [3:0]       pitch_w     = word_w[3:0];
   wire logic [CTL_W-1:0] jump_wd_w   = ctl_at(7'(base_ff + CTL_JUMP_OFS + 7'(pitch_w)));
   wire logic [8:0]       jump_w      = jump_wd_w[8:0];
   wire logic             tsel_nx_w   = tsel_ff ^ word_w[TSW_BIT];
   wire logic             tsrc_w      = (st_ff == ST_NOTE) ? tsel_nx_w : tsel_ff;
   wire logic [15:0]      ticks_w     = tempo_tbl_w[tsrc_w ? tempo_b_ff : tempo_a_ff];
   wire logic             note_end_w  = (st_ff == ST_PLAY) && ref_tick_ff &&
                                        (tick_ff == TICK_ONE) && (dur_ff == DUR_ONE);
   wire logic             end_w       = (st_ff == ST_NOTE) && (kind_w == KIND_END);
   wire logic             repeat_w    = (mode_ff == MODE_LEVEL) && trig_ff;
   wire logic             fin_w       = (note_end_w && stop_req_ff) ||
                                        (end_w && !repeat_w);
   wire logic             chg_w       = note_end_w && !stop_req_ff && chg_req_ff;
   wire logic             start_a_w   = armed_ff && trig_ff && (hold_ff == HOLD_LAST);
   wire logic             start_w     = (st_ff == ST_IDLE) &&
                                        ((mode_ff == MODE_ONE_A) ? start_a_w : trig_rise_w);

   // APB slave: one access cycle, registered answer
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         pready_out  <= 1'b0;
         pslverr_out <= 1'b0;
         prdata_out  <= '0;
      end
      else if (ce_in)
      begin
         pready_out  <= setup_w;
         pslverr_out <= setup_w & ~hit_w;
         if (setup_w)
            prdata_out <= pwrite_in ? '0 : rd_w;
      end
   end

   // Software registers
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         trig_ff  <= 1'b0;
         mode_ff  <= MODE_LEVEL;
         cks_ff   <= 2'h0;
         msel_ff  <= 4'h0;
         mask_ff  <= 1'b0;
         raddr_ff <= '0;
      end
      else if (ce_in && wr_w)
      begin
         if (wr_ctrl_w)
            trig_ff <= pwdata_in[TRIG_BIT];
         if (paddr_in == OFS_MODE)
            mode_ff <= pwdata_in[1:0];
         if (paddr_in == OFS_CKS)
            cks_ff <= pwdata_in[1:0];
         if (wr_msel_w)
            msel_ff <= pwdata_in[3:0];
         if (paddr_in == OFS_MASK)
            mask_ff <= pwdata_in[0];
         if (paddr_in == OFS_RADDR)
            raddr_ff <= pwdata_in[11:0];
      end
   end

   // Memory load window
   always_ff @(posedge mclk_in)
   begin
      if (ce_in && wr_rom_w)
      begin
         case (rsel_w)
            ROM_SCORE: score_mem[raddr_ff[8:0]] <= pwdata_in[SCORE_W-1:0];
            ROM_SCALE: scale_mem[raddr_ff[3:0]] <= pwdata_in[SCALE_W-1:0];
            ROM_CTL:   if (int'(raddr_ff[6:0]) < CTL_WORDS)
                          ctl_mem[raddr_ff[6:0]] <= pwdata_in[CTL_W-1:0];
            default:   start_mem[raddr_ff[3:0]] <= pwdata_in[START_W-1:0];
         endcase
      end
   end

   // Reference tick, end flag, status and shared request
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         osc_q_ff    <= 1'b0;
         div_ff      <= 2'h0;
         ref_tick_ff <= 1'b0;
         flag_ff     <= 1'b0;
         status_ff   <= 1'b0;
         irq_out     <= 1'b0;
      end
      else if (ce_in)
      begin
         osc_q_ff    <= low_speed_osc_in;
         ref_tick_ff <= osc_edge_w & div_last_w;
         if (osc_edge_w)
            div_ff <= div_last_w ? 2'h0 : div_ff + 2'h1;
         if (fin_w)
            flag_ff <= 1'b1;
         else if (wr_flag_w && pwdata_in[0])
            flag_ff <= 1'b0;
         status_ff <= (st_ff != ST_IDLE);
         irq_out   <= (flag_ff & mask_ff) | ga_irq_in;
      end
   end

   // Start qualification and stop or change requests
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         armed_ff    <= 1'b0;
         hold_ff     <= '0;
         stop_req_ff <= 1'b0;
         chg_req_ff  <= 1'b0;
      end
      else if (ce_in)
      begin
         if (st_ff != ST_IDLE || trig_wr0_w || start_w)
            armed_ff <= 1'b0;
         else if (trig_rise_w && mode_ff == MODE_ONE_A)
            armed_ff <= 1'b1;
         hold_ff <= (armed_ff && trig_ff) ? hold_ff + HW'(1) : '0;
         if (st_ff == ST_IDLE)
            stop_req_ff <= 1'b0;
         else if (((mode_ff == MODE_LEVEL || mode_ff == MODE_ONE_C) && trig_wr0_w) ||
                  (mode_ff == MODE_SS && trig_rise_w))
            stop_req_ff <= 1'b1;
         if (st_ff == ST_IDLE || chg_w)
            chg_req_ff <= 1'b0;
         else if (CHANGE_OK && wr_msel_w)
            chg_req_ff <= 1'b1;
      end
   end

   // Score sequencer
   always_ff @(posedge mclk_in)
   begin
      if (rst_in)
      begin
         st_ff      <= ST_IDLE;
         mel_ff     <= 4'h0;
         base_ff    <= '0;
         ptr_ff     <= '0;
         tempo_a_ff <= 4'h0;
         tempo_b_ff <= 4'h0;
         tsel_ff    <= 1'b0;
         tick_ff    <= '0;
         dur_ff     <= '0;
         ratio_ff   <= '0;
         sound_ff   <= 1'b0;
      end
      else if (ce_in)
      begin
         case (st_ff)
            ST_IDLE:
               if (start_w)
               begin
                  st_ff  <= ST_LOAD;
                  mel_ff <= msel_ff;
               end
            ST_LOAD:
            begin
               base_ff    <= start_idx_w;
               ptr_ff     <= start_wd_w[8:0];
               tempo_a_ff <= tempo_wd_w[3:0];
               tempo_b_ff <= tempo_wd_w[7:4];
               tsel_ff    <= 1'b0;
               st_ff      <= ST_NOTE;
            end
            ST_NOTE:
               case (kind_w)
                  KIND_END:  st_ff <= repeat_w ? ST_LOAD : ST_IDLE;
                  KIND_JUMP: ptr_ff <= jump_w;
                  default:
                  begin
                     ratio_ff <= scale_mem[pitch_w];
                     sound_ff <= (kind_w == KIND_NOTE);
                     tsel_ff  <= tsel_nx_w;
                     tick_ff  <= ticks_w;
                     dur_ff   <= dur_units(word_w[DUR_LSB+:3]);
                     ptr_ff   <= ptr_ff + 9'h001;
                     st_ff    <= ST_PLAY;
                  end
               endcase
            ST_PLAY:
               if (ref_tick_ff)
               begin
                  if (tick_ff != TICK_ONE)
                     tick_ff <= tick_ff - 16'h0001;
                  else if (dur_ff != DUR_ONE)
                  begin
                     tick_ff <= ticks_w;
                     dur_ff  <= dur_ff - 5'h01;
                  end
                  else
                  begin
                     sound_ff <= 1'b0;
                     if (stop_req_ff)
                        st_ff <= ST_IDLE;
                     else if (chg_req_ff)
                     begin
                        st_ff  <= ST_LOAD;
                        mel_ff <= msel_ff;
                     end
                     else
                        st_ff <= ST_NOTE;
                  end
               end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   tone_divider #(
      .RATIO_W    (SCALE_W),
      .IDLE_LEVEL (IDLE_LVL)
   ) u_tone (
      .mclk_in     (mclk_in),
      .rst_in      (rst_in),
      .ce_in       (ce_in),
      .ref_tick_in (ref_tick_ff),
      .sound_in    (sound_ff),
      .ratio_in    (ratio_ff),
      .tone_out    (melody_out)
   );

   // Checks
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   sequence s_change;
      ce_in && chg_w;
   endsequence

   sequence s_reload;
      st_ff == ST_LOAD && !flag_ff [*1];
   endsequence

   flag_on_end_a: assert property (ce_in && fin_w |=> flag_ff)
      else $error("end of play did not set the flag");
   irq_share_a: assert property (ce_in |=> irq_out ==
      (($past(flag_ff) & $past(mask_ff)) | $past(ga_irq_in)))
      else $error("shared request does not follow flag, mask and gate-array input");
   chg_silent_a: assert property (s_change and !flag_ff |-> !fin_w ##1 s_reload)
      else $error("melody change raised an interrupt or missed reload");
   no_swap_a: assert property (!CHANGE_OK && ce_in && st_ff != ST_IDLE |=>
      mel_ff == $past(mel_ff))
      else $error("melody switched during play with change barred");
   no_force_a: assert property (st_ff != ST_IDLE && mode_ff == MODE_ONE_A |->
      !stop_req_ff)
      else $error("stop request in one-shot A mode");
   short_hold_a: assert property (ce_in && st_ff == ST_IDLE && mode_ff == MODE_ONE_A &&
      trig_rise_w |=> st_ff == ST_IDLE)
      else $error("one-shot A started without hold time");
   status_track_a: assert property (ce_in |=>
      status_ff == ($past(st_ff) != ST_IDLE))
      else $error("playing status does not track the sequencer");
   start_top_a: assert property (ce_in && start_w |=>
      st_ff == ST_LOAD && mel_ff == $past(msel_ff))
      else $error("start did not load the selected melody");
   c_stop_a: assert property (ce_in && st_ff != ST_IDLE && mode_ff == MODE_ONE_C &&
      trig_wr0_w |=> stop_req_ff || st_ff == ST_IDLE)
      else $error("one-shot C zero write did not request stop");
   quiet_idle_a: assert property (ce_in && st_ff == ST_IDLE |=> melody_out == IDLE_LVL)
      else $error("buzzer line not idle while stopped");
   one_pass_a: assert property (ce_in && end_w && mode_ff != MODE_LEVEL |=>
      st_ff == ST_IDLE)
      else $error("one-shot melody repeated");

endmodule : melody_play_controller

// ===== bench/buzzer_model.sv
// Buzzer drive stage model that counts tone edges
module buzzer_model
(
   // Clock and reset
   input  wire logic  mclk_in,
   input  wire logic  rst_in,
   // Transistor base drive
   input  wire logic  drive_in,
   // Activity seen at the buzzer
   output int unsigned edges_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_ff;
   always_ff @(posedge mclk_in)
   begin
      last_ff <= drive_in;
      if (rst_in)
         edges_out <= 0;
      else if (drive_in !== last_ff)
         edges_out <= edges_out + 1;
   end
endmodule : buzzer_model

// ===== bench/melody_play_controller_test.sv
// Register level testbench of the melody play controller
module melody_play_controller_test import melody_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk_in = 0, rst_in = 1, ce_in = 1, low_speed_osc_in = 0, ga_irq_in = 0;
   logic        psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   logic        pready_out, pslverr_out, irq_out, melody_out, er;
   int unsigned edges;
   int          err_count = 0, check_count = 0, cyc = 0;
   // Memory image: [25:24] memory, [20:12] word, [9:0] data
   logic [25:0] edges_tbl [13] = '{
      {ROM_SCALE, 3'h0, 9'h000, 2'h0, 10'h002}, {ROM_START, 3'h0, 9'h000, 2'h0, 10'h000},
      {ROM_START, 3'h0, 9'h001, 2'h0, 10'h004}, {ROM_CTL, 3'h0, 9'h000, 2'h0, 10'h000},
      {ROM_CTL, 3'h0, 9'h001, 2'h0, 10'h000}, {ROM_CTL, 3'h0, 9'h004, 2'h0, 10'h008},
      {ROM_CTL, 3'h0, 9'h005, 2'h0, 10'h000}, {ROM_SCORE, 3'h0, 9'h000, 2'h0, 10'h000},
      {ROM_SCORE, 3'h0, 9'h001, 2'h0, 10'h100}, {ROM_SCORE, 3'h0, 9'h002, 2'h0, 10'h300},
      {ROM_SCORE, 3'h0, 9'h008, 2'h0, 10'h000}, {ROM_SCORE, 3'h0, 9'h009, 2'h0, 10'h000},
      {ROM_SCORE, 3'h0, 9'h00a, 2'h0, 10'h300}};

   melody_play_controller #(.HOLD_CYC(20)) melody_play_controller_i (.mclk_in(mclk_in),
      .rst_in(rst_in), .ce_in(ce_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .low_speed_osc_in(low_speed_osc_in), .ga_irq_in(ga_irq_in), .irq_out(irq_out),
      .melody_out(melody_out));
   buzzer_model buzzer_model_i (.mclk_in(mclk_in), .rst_in(rst_in), .drive_in(melody_out),
      .edges_out(edges));

   initial
   begin
      forever #20 mclk_in = ~mclk_in;
   end
   // Oscillator rises every second cycle
   always @(posedge mclk_in)
   begin
      cyc <= cyc + 1;
      low_speed_osc_in <= ~low_speed_osc_in;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk_in);
      psel_in <= 1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge mclk_in);
      penable_in <= 1;
      n = 0;
      do
      begin
         @(posedge mclk_in);
         n++;
      end
      while (pready_out !== 1'b1 && n < 50);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 0;
      penable_in <= 0;
      if (pready_out !== 1'b1)
      begin
         err_count++;
         give_verdict;
      end
   endtask : xfer

   task automatic ld(input logic [1:0] sel, input logic [8:0] a, input logic [31:0] d);
      xfer(1, OFS_RADDR, {20'h0, sel, 1'b0, a});
      xfer(1, OFS_RDATA, d);
   endtask : ld

   task automatic wait_stat(input logic v);
      int n;
      n = 0;
      do
      begin
         xfer(0, OFS_CTRL, 32'h0);
         n++;
      end
      while (rd[STAT_BIT] !== v && n < 6000);
      if (n >= 6000)
      begin
         err_count++;
         give_verdict;
      end
   endtask : wait_stat

   // Length class: 0 stopped at first note, 1 whole melody, 2 switched melody
   task automatic run(input logic [1:0] m, input bit early, input bit chg, input int cls);
      int t0;
      int e;
      int unsigned e0;
      xfer(1, OFS_MODE, {30'h0, m});
      xfer(1, OFS_MASK, {31'h0, m[0]});
      e0 = edges;
      xfer(1, OFS_CTRL, 32'h1);
      t0 = cyc;
      wait_stat(1);
      if (chg)
      begin
         xfer(1, OFS_MSEL, 32'h1);
         repeat (3000) @(posedge mclk_in);
         xfer(0, OFS_FLAG, 32'h0);
         chk("flag at change", rd, 32'h0);
      end
      if (early)
         xfer(1, OFS_CTRL, 32'h0);
      wait_stat(0);
      e = cyc - t0;
      chk("length", 32'((e < 2600) ? 0 : (e < 5500) ? 1 : 2), 32'(cls));
      xfer(0, OFS_FLAG, 32'h0);
      chk("flag", rd, 32'h1);
      chk("irq", {31'h0, irq_out}, {31'h0, m[0]});
      chk("tone", {31'h0, edges > e0}, 32'h1);
      chk("idle", {31'h0, melody_out}, 32'h0);
      repeat (2100) @(posedge mclk_in);
      xfer(0, OFS_CTRL, 32'h0);
      chk("repeat", {31'h0, rd[STAT_BIT]}, 32'h0);
      xfer(1, OFS_CTRL, 32'h0);
      xfer(1, OFS_FLAG, 32'h1);
      xfer(1, OFS_MSEL, 32'h0);
      xfer(0, OFS_FLAG, 32'h0);
      chk("flag clear", rd, 32'h0);
      $display("test play mode %0d early %0d change %0d done", m, early, chg);
   endtask : run

   initial
   begin
      repeat (16) @(posedge mclk_in);
      rst_in <= 0;
      xfer(0, OFS_CTRL, 32'h0);
      chk("ctrl reset", rd, 32'h0);
      xfer(0, 8'h20, 32'h0);
      chk("unmapped", {31'h0, er}, 32'h1);
      xfer(1, OFS_CTRL, 32'h2);
      xfer(0, OFS_CTRL, 32'h0);
      chk("status ro", rd, 32'h0);
      ld(ROM_SCORE, 9'h1ff, 32'h2aa);
      xfer(0, OFS_RDATA, 32'h0);
      chk("score top", rd, 32'h2aa);
      foreach (edges_tbl[i]) ld(edges_tbl[i][25:24], edges_tbl[i][20:12], {22'h0, edges_tbl[i][9:0]});
      $display("test setup done");
      xfer(1, OFS_MODE, {30'h0, MODE_ONE_A});
      xfer(1, OFS_CTRL, 32'h1);
      xfer(1, OFS_CTRL, 32'h0);
      repeat (60) @(posedge mclk_in);
      xfer(0, OFS_CTRL, 32'h0);
      chk("short trigger", {31'h0, rd[STAT_BIT]}, 32'h0);
      $display("test short trigger done");
      run(MODE_LEVEL, 1, 0, 0);
      run(MODE_SS, 0, 0, 1);
      run(MODE_ONE_A, 0, 0, 1);
      run(MODE_ONE_A, 1, 0, 1);
      run(MODE_ONE_C, 1, 0, 0);
      run(MODE_ONE_C, 0, 0, 1);
      run(MODE_ONE_A, 0, 1, 2);
      @(posedge mclk_in);
      ga_irq_in <= 1;
      repeat (3) @(posedge mclk_in);
      chk("shared irq", {31'h0, irq_out}, 32'h1);
      ce_in <= 0;
      ga_irq_in <= 0;
      repeat (3) @(posedge mclk_in);
      chk("frozen irq", {31'h0, irq_out}, 32'h1);
      ce_in <= 1;
      repeat (3) @(posedge mclk_in);
      chk("irq released", {31'h0, irq_out}, 32'h0);
      $display("test shared request done");
      give_verdict;
   end
endmodule : melody_play_controller_test
